//--- hw/adp_pipeline.sv
// Module: alpha dot attribute pipeline top with APB registers
//
// Summary of operation
// - Character, attribute and row latched once per character strobe.
// - Pattern address is set select, character code, then row.
// - Pattern word holds seven row dots plus a half-shift flag.
// - Cell is nine dots: one blank each side of seven.
// - Shifter loads a row in load state, then shifts each dot.
// - Serial dots delayed one extra dot to centre the pattern.
// - Second copy captured half a dot later.
// - Inverted latched flag selects undelayed (1) or half-shifted (0).
// - Attribute bits: inverse, blink, underline, reduced intensity.
// - Underline lights the whole bottom row, row count 14.
// - Blink gate is blink attribute AND slow square wave.
// - Square wave is sixth stage of synchronous retrace counter.
// - Intensity and inverse delayed one character time.
// - Dim: half drive low; normal: both low; dark: none.
// - Alpha term merges pattern dots, underline and blink.
// - No graphics, cursor off: lit when alpha differs from inverse.
// - No graphics, cursor on: lit when alpha equals inverse.
// - Graphics, not dim: full when the cursor-adjusted match holds.
// - Graphics with dim attribute: always a full dot.
// - Character strobe runs at one ninth of the dot rate.
`timescale 1ns/1ns
module adp_pipeline
  import adp_pkg::*;
#(
  parameter int CELL_W = adp_pkg::CELL_DOTS
) (
  // Clock and reset
  input  wire logic                       clk_i,
  input  wire logic                       nrst_i,
  // APB slave
  input  wire logic                       psel_i,
  input  wire logic                       penable_i,
  input  wire logic                       pwrite_i,
  input  wire logic [7:0]                 paddr_i,
  input  wire logic [31:0]                pwdata_i,
  output logic      [31:0]                prdata_o,
  output logic                            pready_o,
  output logic                            pslverr_o,
  // Character RAM and controller side
  input  wire logic [adp_pkg::CODE_W-1:0] char_code_i,
  input  wire logic [7:0]                 attr_byte_i,
  input  wire logic [adp_pkg::ROW_W-1:0]  row_count_i,
  input  wire logic                       cursor_i,
  input  wire logic                       vretrace_i,
  input  wire logic                       charset_sw_i,
  input  wire logic                       gfx_pixel_n_i,
  // Character rate strobe and video drives
  output logic                            char_rate_clock_o,
  output logic                            half_n_o,
  output logic                            full_n_o
);
  import adp_pkg::*;

  // ==========================================================
  // Dot and character rate dividers
  logic [3:0] dot_cnt_q;
  logic [3:0] dot_cnt_d;
  logic [1:0] div_q;
  logic       dot_en;
  logic       half_en;
  logic       char_load;

  assign dot_en    = (div_q == 2'(DOT_DIV - 1));
  assign half_en   = (div_q == 2'(HALF_DOT_CYC - 1));
  assign char_load = dot_en && (dot_cnt_q == 4'(CELL_W - 1));
  assign dot_cnt_d = char_load ? 4'h0000 : dot_cnt_q + 4'h0001;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      div_q     <= '0;
      dot_cnt_q <= '0;
    end else begin
      div_q <= dot_en ? 2'h0000 : div_q + 2'h0001;
      if (dot_en) begin
        dot_cnt_q <= dot_cnt_d;
      end
    end
  end

  assign char_rate_clock_o = char_load;

  // ==========================================================
  // Character, attribute and row latches
  logic [CODE_W-1:0] char_q;
  logic [7:0]        attr_q;
  logic [ROW_W-1:0]  row_q;
  logic              cursor_q;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      char_q   <= '0;
      attr_q   <= '0;
      row_q    <= '0;
      cursor_q <= 1'b0;
    end else if (char_load) begin
      char_q   <= char_code_i;
      attr_q   <= attr_byte_i;
      row_q    <= row_count_i;
      cursor_q <= cursor_i;
    end
  end

  // ==========================================================
  // Pattern memory, loaded by software
  logic [PAT_DW-1:0] pat_mem [2**PAT_AW];
  logic [PAT_AW-1:0] pat_addr;
  logic [PAT_DW-1:0] pat_q;
  logic [PAT_AW-1:0] wr_addr_q;
  logic              pat_wr;

  assign pat_addr = {charset_sw_i, char_q, row_q};

  always_ff @(posedge clk_i) begin
    if (pat_wr) begin
      pat_mem[wr_addr_q] <= pwdata_i[PAT_DW-1:0];
    end
    pat_q <= pat_mem[pat_addr];
  end

  // Seven dots centred with a blank either side
  logic [CELL_W-1:0] cell_row;
  logic              half_flag;
  assign cell_row  = {1'b0, pat_q[PAT_DOTS-1:0], 1'b0};
  assign half_flag = pat_q[HALF_FLAG];

  // ==========================================================
  // Serializer and half-dot shift
  logic ser_dot;
  logic dly_dot_q;
  logic half_dot_q;
  logic sel_q;
  logic sel_dot;

  adp_serializer #(
    .WIDTH (CELL_W)
  ) u_ser (
    .clk_i    (clk_i),
    .nrst_i   (nrst_i),
    .dot_en_i (dot_en),
    .load_i   (char_load),
    .row_i    (cell_row),
    .dot_o    (ser_dot)
  );

  // Selector input holds the inverted flag
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      dly_dot_q  <= 1'b0;
      half_dot_q <= 1'b0;
      sel_q      <= 1'b1;
    end else begin
      if (dot_en) begin
        dly_dot_q <= ser_dot;
      end
      if (half_en) begin
        half_dot_q <= dly_dot_q;
      end
      if (char_load) begin
        sel_q <= !half_flag;
      end
    end
  end

  assign sel_dot = sel_q ? dly_dot_q : half_dot_q;

  // ==========================================================
  // Attribute delay and blink source
  logic                    inv_d_q;
  logic                    dim_d_q;
  logic                    ul_d_q;
  logic                    blink_d_q;
  logic                    cursor_d_q;
  logic [BLINK_STAGES-1:0] blink_cnt_q;
  logic                    vr_q;
  logic                    blink_gate;
  logic                    ul_row;

  // Row and underline travel with the pattern they belong to
  assign ul_row = attr_q[ATTR_UL] && (row_q == UL_ROW);

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      inv_d_q    <= 1'b0;
      dim_d_q    <= 1'b0;
      ul_d_q     <= 1'b0;
      blink_d_q  <= 1'b0;
      cursor_d_q <= 1'b0;
    end else if (char_load) begin
      inv_d_q    <= attr_q[ATTR_INV];
      dim_d_q    <= attr_q[ATTR_DIM];
      ul_d_q     <= ul_row;
      blink_d_q  <= attr_q[ATTR_BLINK];
      cursor_d_q <= cursor_q;
    end
  end

  // Synchronous counter stands in for the ripple chain, same tap
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      vr_q        <= 1'b0;
      blink_cnt_q <= '0;
    end else begin
      vr_q <= vretrace_i;
      if (vretrace_i && !vr_q) begin
        blink_cnt_q <= blink_cnt_q + 1'b1;
      end
    end
  end

  assign blink_gate = blink_d_q & blink_cnt_q[BLINK_TAP];

  // ==========================================================
  // Alpha term and graphics alignment
  logic alpha;
  logic gfx_q;

  assign alpha = (sel_dot | ul_d_q) & !blink_gate;

  // Sampled every cycle, so it lines up with the selected stream
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      gfx_q <= 1'b0;
    end else begin
      gfx_q <= !gfx_pixel_n_i;
    end
  end

  // ==========================================================
  // APB registers
  logic        vid_en_q;
  logic        apb_wr;
  logic        apb_rd;
  logic        hit;
  logic [31:0] rd_mux;

  assign apb_wr = psel_i && penable_i && pwrite_i;
  assign apb_rd = psel_i && !penable_i && !pwrite_i;
  assign hit    = (paddr_i == OFS_CTRL) || (paddr_i == OFS_STATUS)
               || (paddr_i == OFS_PAT_ADDR) || (paddr_i == OFS_PAT_DATA);
  assign pat_wr = apb_wr && (paddr_i == OFS_PAT_DATA);
  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i && penable_i && !hit;

  assign rd_mux = (paddr_i == OFS_CTRL)     ? {31'h0000_0000, vid_en_q} :
                  (paddr_i == OFS_STATUS)   ? {24'h00_0000, blink_cnt_q} :
                  (paddr_i == OFS_PAT_ADDR) ? {19'h0_0000, wr_addr_q} :
                  32'h0000_0000;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      vid_en_q  <= CTRL_RESET;
      wr_addr_q <= '0;
      prdata_o  <= '0;
    end else begin
      if (apb_rd) begin
        prdata_o <= rd_mux;
      end
      if (apb_wr && paddr_i == OFS_CTRL) begin
        vid_en_q <= pwdata_i[CTRL_VID_EN];
      end
      if (apb_wr && paddr_i == OFS_PAT_ADDR) begin
        wr_addr_q <= pwdata_i[PAT_AW-1:0];
      end else if (pat_wr) begin
        wr_addr_q <= wr_addr_q + 1'b1;
      end
    end
  end

  // ==========================================================
  // Mixer
  adp_mixer u_mix (
    .clk_i    (clk_i),
    .nrst_i   (nrst_i),
    .enable_i (vid_en_q),
    .gfx_i    (gfx_q),
    .dim_i    (dim_d_q),
    .inv_i    (inv_d_q),
    .alpha_i  (alpha),
    .cursor_i (cursor_d_q),
    .half_n_o (half_n_o),
    .full_n_o (full_n_o)
  );

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  a_char_latch: assert property (
    char_load |=> char_q == $past(char_code_i) && row_q == $past(row_count_i)
               && attr_q == $past(attr_byte_i))
    else $error("character latch missed");
  a_strobe_period: assert property (
    char_load |=> !char_load [*8])
    else $error("strobe too soon");
  a_strobe_repeat: assert property (
    char_load |-> ##18 char_load)
    else $error("strobe period not nine dots");
  a_pattern_addr: assert property (
    ##1 $past(pat_addr) == {$past(charset_sw_i), $past(char_q), $past(row_q)})
    else $error("pattern address wrong");
  a_centre_delay: assert property (
    dot_en |=> dly_dot_q == $past(ser_dot))
    else $error("centre delay wrong");
  a_half_copy: assert property (
    half_en |=> half_dot_q == $past(dly_dot_q))
    else $error("half copy wrong");
  a_shift_select: assert property (
    char_load |=> sel_q == !$past(pat_q[HALF_FLAG]))
    else $error("half-shift select wrong");
  a_blink_gate: assert property (
    !blink_d_q |-> !blink_gate)
    else $error("blink gate with attribute clear");
  a_blink_tap: assert property (
    vretrace_i && !vr_q |=> blink_cnt_q == $past(blink_cnt_q) + 8'h01)
    else $error("retrace count missed");
  a_attr_delay: assert property (
    char_load |=> inv_d_q == $past(attr_q[ATTR_INV])
               && dim_d_q == $past(attr_q[ATTR_DIM]))
    else $error("attribute delay wrong");
  a_underline_row: assert property (
    char_load && attr_q[ATTR_UL] && row_q == UL_ROW |=> ul_d_q)
    else $error("underline row missed");
  a_gfx_align: assert property (
    !gfx_pixel_n_i |=> gfx_q)
    else $error("graphics dot not sampled");
  a_load_first: assert property (
    char_load |=> ser_dot == $past(cell_row[CELL_W-1]))
    else $error("shifter did not load the row");
  a_dot_hold: assert property (
    !dot_en |=> $stable(dly_dot_q))
    else $error("dot changed inside its period");
  a_ul_full_dot: assert property (
    vid_en_q && ul_d_q && !blink_gate && !inv_d_q && !cursor_d_q
    && !gfx_q && !dim_d_q |=> !half_n_o && !full_n_o)
    else $error("underline dot not lit");
  a_blink_dark: assert property (
    vid_en_q && blink_gate && !inv_d_q && !cursor_d_q && !gfx_q
    |=> half_n_o && full_n_o)
    else $error("blinked dot not hidden");
endmodule // adp_pipeline

//--- hw/adp_pkg.sv
// Package: constants shared by the alpha dot attribute pipeline
package adp_pkg;
  // ==========================================================
  // Cell geometry and memory shape
  localparam int CELL_DOTS    = 9;
  localparam int PAT_DOTS     = 7;
  localparam int CODE_W       = 8;
  localparam int ROW_W        = 4;
  localparam int PAT_AW       = 1 + CODE_W + ROW_W;
  localparam int PAT_DW       = 8;
  localparam int HALF_FLAG    = 7;
  localparam logic [ROW_W-1:0] UL_ROW = 4'h000E;
  // Attribute byte layout
  localparam int ATTR_INV     = 0;
  localparam int ATTR_BLINK   = 1;
  localparam int ATTR_UL      = 2;
  localparam int ATTR_DIM     = 3;
  // Blink counter: eight stages, sixth stage is the square wave
  localparam int BLINK_STAGES = 8;
  localparam int BLINK_TAP    = 5;
  // ==========================================================
  // Timing: dot period spans two clk cycles so half a dot is one
  localparam int CLK_MHZ      = 100;
  localparam int DOT_DIV      = 2;
  localparam int HALF_DOT_CYC = DOT_DIV / 2;
  // ==========================================================
  // APB register map
  localparam logic [7:0] OFS_CTRL     = 8'h0000;
  localparam logic [7:0] OFS_STATUS   = 8'h0004;
  localparam logic [7:0] OFS_PAT_ADDR = 8'h0008;
  localparam logic [7:0] OFS_PAT_DATA = 8'h000C;
  localparam int         CTRL_VID_EN  = 0;
  localparam logic       CTRL_RESET   = 1'b0;
endpackage

//--- hw/adp_serializer.sv
// Module: nine-dot parallel-in serial-out shifter
`timescale 1ns/1ns
module adp_serializer #(
  parameter int WIDTH = 9
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             nrst_i,
  // Control
  input  wire logic             dot_en_i,
  input  wire logic             load_i,
  input  wire logic [WIDTH-1:0] row_i,
  // Serial dot
  output logic                  dot_o
);
  logic [WIDTH-1:0] shreg_q;

  // Load on a dot edge in the load state, else shift MSB first
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      shreg_q <= '0;
    end else if (dot_en_i) begin
      if (load_i) begin
        shreg_q <= row_i;
      end else begin
        shreg_q <= {shreg_q[WIDTH-2:0], 1'b0};
      end
    end
  end

  assign dot_o = shreg_q[WIDTH-1];
endmodule // adp_serializer

//--- hw/adp_mixer.sv
// Module: dot, attribute, cursor and graphics mixer
`timescale 1ns/1ns
module adp_mixer (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic nrst_i,
  // Mixer inputs
  input  wire logic enable_i,
  input  wire logic gfx_i,
  input  wire logic dim_i,
  input  wire logic inv_i,
  input  wire logic alpha_i,
  input  wire logic cursor_i,
  // Intensity drives, active low
  output logic      half_n_o,
  output logic      full_n_o
);
  logic same;
  logic lit;
  logic bright;

  assign same = (alpha_i == inv_i);
  // Graphics inverts the cursor sense; graphics with dim is always lit
  assign lit = gfx_i ? (dim_i | (cursor_i ^ same))
                     : (cursor_i ? same : !same);
  assign bright = gfx_i | !dim_i;

  // Both drives low for a normal dot, only half low for dim
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      half_n_o <= 1'b1;
      full_n_o <= 1'b1;
    end else begin
      half_n_o <= !(enable_i & lit);
      full_n_o <= !(enable_i & lit & bright);
    end
  end

  a_gfx_dim_full: assert property (@(posedge clk_i) disable iff (!nrst_i)
    enable_i && gfx_i && dim_i |=> !half_n_o && !full_n_o)
    else $error("graphics dim dot not full");
  a_dim_half_only: assert property (@(posedge clk_i) disable iff (!nrst_i)
    enable_i && !gfx_i && dim_i && !cursor_i && !same
    |=> !half_n_o && full_n_o)
    else $error("dim alpha dot not half");
endmodule // adp_mixer

//--- tb/adp_partner.sv
// Partner model: character RAM, CRT controller and video output stage
`timescale 1ns/1ns
module adp_partner (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       nrst_i,
  // Screen content asked for by the bench
  input  wire logic [7:0] code_i,
  input  wire logic [7:0] attr_i,
  input  wire logic [3:0] row_i,
  input  wire logic       cursor_i,
  input  wire logic       gfx_on_i,
  input  wire logic       retrace_req_i,
  // Pipeline strobe and drives
  input  wire logic       strobe_i,
  input  wire logic       half_n_i,
  input  wire logic       full_n_i,
  // Towards the pipeline
  output logic [7:0]      char_code_o,
  output logic [7:0]      attr_byte_o,
  output logic [3:0]      row_count_o,
  output logic            cursor_o,
  output logic            vretrace_o,
  output logic            gfx_pixel_n_o,
  // Video stage level: 0 dark, 1 half, 2 full, 3 illegal
  output logic [1:0]      level_o
);
  // ==========================================================
  // Refresh fetch
  // A new cell appears only after the capture edge, so the pipeline
  // never sees a cell change inside its own character time
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      char_code_o <= 8'h00;
      attr_byte_o <= 8'h00;
      row_count_o <= 4'h0;
      cursor_o    <= 1'b0;
    end else if (strobe_i) begin
      char_code_o <= code_i;
      attr_byte_o <= attr_i;
      row_count_o <= row_i;
      cursor_o    <= cursor_i;
    end
  end
  // Retrace toggles while asked, one rising edge per two clocks
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      vretrace_o <= 1'b0;
    end else begin
      vretrace_o <= retrace_req_i & ~vretrace_o;
    end
  end
  // ==========================================================
  // Graphics source and output stage
  assign gfx_pixel_n_o = ~gfx_on_i;
  assign level_o = !full_n_i ? (!half_n_i ? 2'h2 : 2'h3)
                             : {1'b0, ~half_n_i};
endmodule // adp_partner

//--- tb/testbench.sv
// Testbench: self-checking run of the alpha dot attribute pipeline
`timescale 1ns/1ns
module testbench;
  import adp_pkg::*;
  logic        clk, nrst, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, code, attr, d_code, d_attr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  row, d_row;
  logic        cur, gfx, rt, cs, d_cur, d_rt, d_gfx_n, stb, half_n, full_n;
  logic        e;
  logic [1:0]  lvl;
  int          err_total, checked, rise, o1;

  adp_pipeline u_dut (.clk_i(clk), .nrst_i(nrst), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .char_code_i(d_code), .attr_byte_i(d_attr),
    .row_count_i(d_row), .cursor_i(d_cur), .vretrace_i(d_rt),
    .charset_sw_i(cs), .gfx_pixel_n_i(d_gfx_n), .char_rate_clock_o(stb),
    .half_n_o(half_n), .full_n_o(full_n));
  adp_partner u_far (.clk_i(clk), .nrst_i(nrst), .code_i(code),
    .attr_i(attr), .row_i(row), .cursor_i(cur), .gfx_on_i(gfx),
    .retrace_req_i(rt), .strobe_i(stb), .half_n_i(half_n),
    .full_n_i(full_n), .char_code_o(d_code), .attr_byte_o(d_attr),
    .row_count_o(d_row), .cursor_o(d_cur), .vretrace_o(d_rt),
    .gfx_pixel_n_o(d_gfx_n), .level_o(lvl));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ==========================================================
  // Checking and closing
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Bounded wait for the character strobe, seen at a falling edge
  task automatic wait_stb();
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (stb !== 1'b1 && n < 40);
    if (n >= 40) begin
      err_total++;
      $display("wrong value at %0t: strobe never came", $time);
      summarize();
    end
  endtask
  // ==========================================================
  // APB master: setup, then access held until pready is sampled
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    e  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      err_total++;
      $display("wrong value at %0t: pready never came", $time);
      summarize();
    end
  endtask
  task automatic pat(input logic [12:0] a, input logic [7:0] d);
    apb(1'b1, OFS_PAT_ADDR, {19'h0_0000, a});
    apb(1'b1, OFS_PAT_DATA, {24'h00_0000, d});
  endtask
  // ==========================================================
  // One steady cell, repeated; lit and full clock cycles counted per cell
  task automatic run(input logic c, input logic [3:0] r,
                     input logic [7:0] at, input logic cu, input logic g,
                     input int el, input int ef);
    int lit, full, ill, s;
    logic prev;
    @(posedge clk);
    cs   <= c;
    row  <= r;
    attr <= at;
    cur  <= cu;
    gfx  <= g;
    repeat (4) wait_stb();
    wait_stb();
    {lit, full, ill, s} = '0;
    rise = -1;
    prev = (lvl != 2'h0);
    for (int i = 0; i < 18; i++) begin
      @(negedge clk);
      if (lvl != 2'h0 && !prev && rise < 0) rise = i;
      prev = (lvl != 2'h0);
      lit  += (lvl != 2'h0);
      full += (lvl == 2'h2);
      ill  += (lvl == 2'h3);
      s    += (stb === 1'b1);
    end
    chk(s, 1);
    chk(stb, 1'b1);
    chk(ill, 0);
    chk(lit, el);
    chk(full, ef);
    $display("test row %0h attr %0h cursor %0b gfx %0b done", r, at, cu, g);
  endtask

  initial begin
    {nrst, psel, penable, pwrite, cur, gfx, rt, cs} = 8'h00;
    paddr  = 8'h00;
    pwdata = 32'h0000_0000;
    code   = 8'h41;
    attr   = 8'h00;
    row    = 4'h3;
    err_total = 0;
    checked   = 0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    // Cells read before the first strobe and while cs changes must be set
    pat(13'h0000, 8'h00);
    apb(1'b0, OFS_CTRL, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    apb(1'b0, 8'h10, 32'h0000_0000);
    chk(e, 1'b1);
    pat(13'h0413, 8'h7F);
    pat(13'h1413, 8'h08);
    pat(13'h041E, 8'h00);
    pat(13'h141E, 8'h00);
    pat(13'h0414, 8'hC0);
    pat(13'h0415, 8'h40);
    pat(13'h0416, 8'h01);
    apb(1'b0, OFS_PAT_DATA, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    run(1'b0, 4'h3, 8'h00, 1'b0, 1'b0, 0, 0);
    apb(1'b1, OFS_CTRL, 32'h0000_0001);
    apb(1'b0, OFS_CTRL, 32'h0000_0000);
    chk(rd, 32'h0000_0001);
    run(1'b0, 4'h3, 8'h00, 1'b0, 1'b0, 14, 14);
    run(1'b0, 4'h3, 8'h01, 1'b0, 1'b0, 4, 4);
    run(1'b0, 4'h3, 8'h08, 1'b0, 1'b0, 14, 0);
    run(1'b0, 4'h3, 8'h00, 1'b1, 1'b0, 4, 4);
    run(1'b0, 4'h3, 8'h01, 1'b1, 1'b0, 14, 14);
    run(1'b0, 4'h3, 8'h08, 1'b1, 1'b0, 4, 0);
    run(1'b0, 4'h3, 8'h00, 1'b0, 1'b1, 4, 4);
    run(1'b0, 4'h3, 8'h00, 1'b1, 1'b1, 14, 14);
    run(1'b0, 4'h3, 8'h09, 1'b1, 1'b1, 18, 18);
    run(1'b0, 4'hE, 8'h04, 1'b0, 1'b0, 18, 18);
    run(1'b0, 4'hE, 8'h00, 1'b0, 1'b0, 0, 0);
    run(1'b1, 4'h3, 8'h00, 1'b0, 1'b0, 2, 2);
    run(1'b0, 4'h5, 8'h00, 1'b0, 1'b0, 2, 2);
    o1 = rise;
    run(1'b0, 4'h4, 8'h00, 1'b0, 1'b0, 2, 2);
    chk((rise - o1 + 18) % 18, 1);
    run(1'b0, 4'h6, 8'h00, 1'b0, 1'b0, 2, 2);
    chk((rise - o1 + 18) % 18, 12);
    run(1'b0, 4'h3, 8'h02, 1'b0, 1'b0, 14, 14);
    for (int k = 1; k <= 2; k++) begin
      @(posedge clk);
      rt <= 1'b1;
      repeat (64) @(posedge clk);
      rt <= 1'b0;
      apb(1'b0, OFS_STATUS, 32'h0000_0000);
      chk(rd, 32 * k);
      run(1'b0, 4'h3, 8'h02, 1'b0, 1'b0, 14 * (k - 1), 14 * (k - 1));
    end
    // Another character code picks another pattern word
    pat(13'h0423, 8'h08);
    @(posedge clk);
    code <= 8'h42;
    run(1'b0, 4'h3, 8'h00, 1'b0, 1'b0, 2, 2);
    summarize();
  end
endmodule // testbench
